// File: hw/ppms_pkg.sv
// ppms_pkg: shared constants and types for the parallel port mode selection block
package ppms_pkg;

  // active operating mode of the port
  typedef enum logic [2:0] {
    PPMS_SPP_COMPAT = 3'h0,
    PPMS_SPP_EXT    = 3'h1,
    PPMS_EPP17      = 3'h2,
    PPMS_EPP19      = 3'h3,
    PPMS_ECP        = 3'h4,
    PPMS_FIFO_PRN   = 3'h5
  } ppms_mode_t;

  localparam int unsigned PPMS_NUM_MODES = 6;

  // offsets from the port base address
  localparam logic [10:0] PPMS_OFS_ECR = 11'h402;
  localparam logic [10:0] PPMS_OFS_IDX = 11'h403;
  localparam logic [10:0] PPMS_OFS_DATA = 11'h404;

  // second-level register file behind the index and data pair
  localparam int unsigned PPMS_SEC_REGS = 8;
  localparam logic [2:0] PPMS_SEC_CTRL2 = 3'h2;

  // configuration space indices
  localparam logic [7:0] PPMS_CFG_IDX_PP = 8'hF0;
  localparam logic [7:0] PPMS_CFG_IDX_IRQ = 8'h70;
  localparam logic [7:0] PPMS_CFG_IDX_DMA = 8'h74;

  // field positions
  localparam int unsigned PPMS_MODE_HI = 7;
  localparam int unsigned PPMS_MODE_LO = 5;
  localparam int unsigned PPMS_CFG_DYN_BIT = 4;
  localparam int unsigned PPMS_CTRL2_COMPAT_BIT = 7;
  localparam int unsigned PPMS_CTRL2_EPP_BIT = 4;
  localparam int unsigned PPMS_FUNCTION_ENABLE_ONE_PP_BIT = 4;

  // configuration mode field codes
  localparam logic [2:0] PPMS_CFG_SPP_COMPAT = 3'h0;
  localparam logic [2:0] PPMS_CFG_SPP_EXT = 3'h1;
  localparam logic [2:0] PPMS_CFG_EPP17 = 3'h2;
  localparam logic [2:0] PPMS_CFG_EPP19 = 3'h3;
  localparam logic [2:0] PPMS_CFG_DYN_A = 3'h6;
  localparam logic [2:0] PPMS_CFG_DYN_B = 3'h7;

  // extended control mode field codes
  localparam logic [2:0] PPMS_ECR_SPP = 3'h0;
  localparam logic [2:0] PPMS_ECR_EXT = 3'h1;
  localparam logic [2:0] PPMS_ECR_FIFO = 3'h2;
  localparam logic [2:0] PPMS_ECR_ECP = 3'h3;
  localparam logic [2:0] PPMS_ECR_EPP = 3'h4;

  // reset values
  localparam logic [7:0] PPMS_CFG_RST = 8'hF0;
  localparam logic [7:0] PPMS_ECR_RST = 8'h60;
  localparam logic [7:0] PPMS_IDX_RST = 8'h00;
  localparam logic [7:0] PPMS_SEC_RST = 8'h00;
  localparam logic [3:0] PPMS_IRQ_RST = 4'h0;
  localparam logic [1:0] PPMS_DMA_RST = 2'h3;
  localparam logic [7:0] PPMS_DATA_RST = 8'h00;

  // ecp fifo size and dma channel count
  localparam logic [4:0] PPMS_ECP_FIFO_DEPTH = 5'h10;
  localparam int unsigned PPMS_DMA_CHANNELS = 3;
  localparam int unsigned PPMS_IRQ_LINES = 16;
  localparam logic [3:0] PPMS_IRQ_EXCL_A = 4'h2;
  localparam logic [3:0] PPMS_IRQ_EXCL_B = 4'hD;

endpackage : ppms_pkg

// File: hw/ppms_sync3.sv
// ppms_sync3: three-stage synchroniser for a pin with a filtered level and edge pulses
`timescale 1ns/1ns
module ppms_sync3
  import ppms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_q, s2_q, s3_q; // synchroniser chain
  logic lvl_q, lvl_d; // accepted level
  logic rise_q, rise_d; // one-cycle rising pulse
  logic fall_q, fall_d; // one-cycle falling pulse

  // accept a change once stage two and three agree
  always_comb begin
    lvl_d = lvl_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (s2_q == s3_q && s3_q != lvl_q) begin
      lvl_d = s3_q;
      rise_d = s3_q;
      fall_d = ~s3_q;
    end
  end

  // registers; strobes idle high
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign level = lvl_q;
  assign rise = rise_q;
  assign fall = fall_q;

endmodule : ppms_sync3

// File: hw/ppms_route.sv
// ppms_route: routes the port interrupt and dma request onto selected isa lines
`timescale 1ns/1ns
module ppms_route
  import ppms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic [3:0] irq_sel,
  input wire logic [1:0] dma_sel,
  input wire logic port_irq,
  input wire logic port_drq,
  input wire logic [2:0] dack_n_line,
  output logic [15:0] irq_line,
  output logic [2:0] drq_line,
  output logic port_dack_n
);

  // true for isa lines the port may drive
  function automatic logic irq_ok(input logic [3:0] n);
    irq_ok = (n != 4'h0) && (n != PPMS_IRQ_EXCL_A) && (n != PPMS_IRQ_EXCL_B);
  endfunction : irq_ok

  logic [15:0] irq_q, irq_d; // registered interrupt lines
  logic [2:0] drq_q, drq_d; // registered dma requests

  // one line per isa interrupt
  genvar gi;
  generate
    for (gi = 0; gi < PPMS_IRQ_LINES; gi++) begin : g_irq
      assign irq_d[gi] = enable && port_irq && irq_ok(irq_sel) && (irq_sel == 4'(gi)); // RULE_13
    end
    for (gi = 0; gi < PPMS_DMA_CHANNELS; gi++) begin : g_drq
      assign drq_d[gi] = enable && port_drq && (dma_sel == 2'(gi)); // RULE_14
    end
  endgenerate

  // register the routed requests
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_q <= 16'h0000;
      drq_q <= 3'h0;
    end else begin
      irq_q <= irq_d;
      drq_q <= drq_d;
    end
  end

  assign irq_line = irq_q;
  assign drq_line = drq_q;
  // acknowledge comes back from the selected channel only
  assign port_dack_n = (enable && dma_sel < 2'h3) ? dack_n_line[dma_sel] : 1'b1; // RULE_14

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_irq_excluded: assert property (!irq_line[2] && !irq_line[13] && !irq_line[0]) // RULE_13
    else $error("excluded interrupt line driven");
  a_dma_single: assert property ($onehot0(drq_line) && (drq_line == 3'h0 || $past(port_drq))) // RULE_14
    else $error("dma request on more than one channel or without cause");

endmodule : ppms_route

// File: hw/ppms_mode_select.sv
// ppms_mode_select: parallel port mode selection, indirect registers and resource routing
//
// Overview of operation
// RULE_01: five software-selectable modes, plus fifo printer
// RULE_02: spp compatible drives data lines only
// RULE_03: fifo printer mode adds hardware handshake fifo
// RULE_04: spp extended moves bytes both ways
// RULE_05: only epp 1.7 lacks 1284 handshake
// RULE_06: ecp has sixteen-entry bidirectional fifo with dma
// RULE_07: reset leaves the port in ecp
// RULE_08: ecp sub-mode from extended control bits 7-5
// RULE_09: static mode from config f0h bits 7-4; the code takes the mode field from bits 7-5
// RULE_10: run-time change needs bit4 and 110/111
// RULE_11: dynamic mode from extended control plus second_control_reg
// RULE_12: second_control_reg reached through index and data registers
// RULE_13: interrupt to irq1-15 except 2 and 13
// RULE_14: dma to one of three channels
// RULE_15: port works only while enable bit set
// RULE_16: software sets config bit4 before dynamic changes
// RULE_17: second_control_reg bit7 refines compatibility behaviour
// RULE_18: exactly one stable active mode
// RULE_19: static configuration ignores run-time mode writes
`timescale 1ns/1ns
module ppms_mode_select
  import ppms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [10:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic [7:0] io_data_in,
  output logic [7:0] io_data_out,
  output logic io_data_oe,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic [7:0] func_enable_one,
  output logic port_enable,
  output ppms_mode_t active_mode,
  output logic [5:0] mode_active,
  output logic [2:0] ecp_sub_mode,
  output logic compat_refine,
  output logic ieee1284_ok,
  output logic pd_out_only,
  output logic pd_bidir,
  output logic hw_handshake,
  output logic fifo_enable,
  output logic fifo_bidir,
  output logic [4:0] fifo_depth,
  output logic dma_capable,
  input wire logic port_irq,
  input wire logic port_drq,
  input wire logic [2:0] dack_n_line,
  output logic [15:0] irq_line,
  output logic [2:0] drq_line,
  output logic port_dack_n
);

  // true when the offset selects one of this block's registers
  function automatic logic reg_hit(input logic [10:0] a);
    reg_hit = (a == PPMS_OFS_ECR) || (a == PPMS_OFS_IDX) || (a == PPMS_OFS_DATA);
  endfunction : reg_hit

  // true when configuration allows run-time reconfiguration
  function automatic logic dyn_cfg(input logic [7:0] c);
    dyn_cfg = c[PPMS_CFG_DYN_BIT] &&
      (c[PPMS_MODE_HI:PPMS_MODE_LO] == PPMS_CFG_DYN_A || c[PPMS_MODE_HI:PPMS_MODE_LO] == PPMS_CFG_DYN_B);
  endfunction : dyn_cfg

  // mode decode from configuration, extended control and second_control_reg
  function automatic ppms_mode_t decode_mode(input logic [7:0] c, input logic [7:0] e, input logic [7:0] c2);
    logic [2:0] sf;
    logic [2:0] ef;
    sf = c[PPMS_MODE_HI:PPMS_MODE_LO];
    ef = e[PPMS_MODE_HI:PPMS_MODE_LO];
    decode_mode = PPMS_ECP;
    if (dyn_cfg(c)) begin // RULE_10 RULE_11
      if (ef == PPMS_ECR_SPP) begin
        decode_mode = PPMS_SPP_COMPAT;
      end else if (ef == PPMS_ECR_EXT) begin
        decode_mode = PPMS_SPP_EXT;
      end else if (ef == PPMS_ECR_FIFO) begin
        decode_mode = PPMS_FIFO_PRN;
      end else if (ef == PPMS_ECR_EPP) begin
        decode_mode = c2[PPMS_CTRL2_EPP_BIT] ? PPMS_EPP19 : PPMS_EPP17;
      end else begin
        decode_mode = PPMS_ECP; // RULE_08
      end
    end else if (sf == PPMS_CFG_SPP_COMPAT) begin // RULE_09 RULE_19
      decode_mode = PPMS_SPP_COMPAT;
    end else if (sf == PPMS_CFG_SPP_EXT) begin
      decode_mode = PPMS_SPP_EXT;
    end else if (sf == PPMS_CFG_EPP17) begin
      decode_mode = PPMS_EPP17;
    end else if (sf == PPMS_CFG_EPP19) begin
      decode_mode = PPMS_EPP19;
    end else begin
      decode_mode = PPMS_ECP;
    end
  endfunction : decode_mode

  // synchronised bus strobes
  logic rd_lvl; // read strobe level, low while reading
  logic wr_lvl; // write strobe level, low while writing
  logic wr_rise; // end of a write cycle

  ppms_sync3 u_rd_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(io_rd_n),
    .level(rd_lvl),
    .rise(),
    .fall()
  );

  ppms_sync3 u_wr_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(io_wr_n),
    .level(wr_lvl),
    .rise(wr_rise),
    .fall()
  );

  // register file state
  logic [7:0] din_q, din_d; // last data seen during a write
  logic [7:0] ecr_q, ecr_d; // extended_mode_control
  logic [7:0] idx_q, idx_d; // mode_index_pointer
  logic [7:0] sec_q [0:PPMS_SEC_REGS-1]; // second-level registers
  logic [7:0] sec_d [0:PPMS_SEC_REGS-1];
  logic [7:0] cfg_q, cfg_d; // port configuration at f0h
  logic [3:0] irq_sel_q, irq_sel_d; // interrupt line number
  logic [1:0] dma_sel_q, dma_sel_d; // dma channel, 3 means none
  logic [7:0] cfg_rd_q, cfg_rd_d; // configuration readback
  logic [7:0] dout_q, dout_d; // bus read data
  logic oe_q, oe_d; // bus data drive enable
  ppms_mode_t mode_q, mode_d; // active operating mode
  logic fe; // port enable bit
  logic sec_ok; // index points inside the second-level file
  logic [7:0] ctrl2; // second_control_reg

  assign fe = func_enable_one[PPMS_FUNCTION_ENABLE_ONE_PP_BIT]; // RULE_15
  assign sec_ok = (idx_q[7:3] == 5'h00);
  assign ctrl2 = sec_q[PPMS_SEC_CTRL2];

  // next values for registers, bus reads and mode
  always_comb begin
    din_d = din_q;
    ecr_d = ecr_q;
    idx_d = idx_q;
    cfg_d = cfg_q;
    irq_sel_d = irq_sel_q;
    dma_sel_d = dma_sel_q;
    cfg_rd_d = cfg_rd_q;
    for (int i = 0; i < PPMS_SEC_REGS; i++) begin
      sec_d[i] = sec_q[i];
    end
    // keep the data present while the write strobe is low
    if (!wr_lvl) begin
      din_d = io_data_in;
    end
    // commit a write at the end of the strobe
    if (fe && wr_rise) begin // RULE_15
      if (io_addr == PPMS_OFS_ECR) begin
        ecr_d = din_q; // RULE_08
      end else if (io_addr == PPMS_OFS_IDX) begin
        idx_d = din_q; // RULE_12
      end else if (io_addr == PPMS_OFS_DATA && sec_ok) begin
        sec_d[idx_q[2:0]] = din_q; // RULE_12
      end
    end
    // configuration space writes from the plug and play logic
    if (cfg_wr) begin
      if (cfg_index == PPMS_CFG_IDX_PP) begin
        cfg_d = cfg_wdata; // RULE_09
      end else if (cfg_index == PPMS_CFG_IDX_IRQ) begin
        irq_sel_d = cfg_wdata[3:0]; // RULE_13
      end else if (cfg_index == PPMS_CFG_IDX_DMA) begin
        dma_sel_d = cfg_wdata[1:0]; // RULE_14
      end
    end
    // configuration readback
    if (cfg_index == PPMS_CFG_IDX_PP) begin
      cfg_rd_d = cfg_q;
    end else if (cfg_index == PPMS_CFG_IDX_IRQ) begin
      cfg_rd_d = {4'h0, irq_sel_q};
    end else if (cfg_index == PPMS_CFG_IDX_DMA) begin
      cfg_rd_d = {6'h00, dma_sel_q};
    end else begin
      cfg_rd_d = 8'h00;
    end
    // bus read, driven only while enabled and mapped
    oe_d = fe && !rd_lvl && reg_hit(io_addr); // RULE_15
    if (io_addr == PPMS_OFS_ECR) begin
      dout_d = ecr_q;
    end else if (io_addr == PPMS_OFS_IDX) begin
      dout_d = idx_q;
    end else if (io_addr == PPMS_OFS_DATA && sec_ok) begin
      dout_d = sec_q[idx_q[2:0]]; // RULE_12
    end else begin
      dout_d = 8'h00;
    end
    // one mode, recomputed only from stored selections
    mode_d = decode_mode(cfg_q, ecr_q, ctrl2); // RULE_18 RULE_01
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      din_q <= PPMS_DATA_RST;
      ecr_q <= PPMS_ECR_RST;
      idx_q <= PPMS_IDX_RST;
      cfg_q <= PPMS_CFG_RST;
      irq_sel_q <= PPMS_IRQ_RST;
      dma_sel_q <= PPMS_DMA_RST;
      cfg_rd_q <= PPMS_DATA_RST;
      dout_q <= PPMS_DATA_RST;
      oe_q <= 1'b0;
      mode_q <= PPMS_ECP; // RULE_07
      for (int i = 0; i < PPMS_SEC_REGS; i++) begin
        sec_q[i] <= PPMS_SEC_RST;
      end
    end else begin
      din_q <= din_d;
      ecr_q <= ecr_d;
      idx_q <= idx_d;
      cfg_q <= cfg_d;
      irq_sel_q <= irq_sel_d;
      dma_sel_q <= dma_sel_d;
      cfg_rd_q <= cfg_rd_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      mode_q <= mode_d;
      for (int i = 0; i < PPMS_SEC_REGS; i++) begin
        sec_q[i] <= sec_d[i];
      end
    end
  end

  // one-hot view of the active mode
  genvar gm;
  generate
    for (gm = 0; gm < PPMS_NUM_MODES; gm++) begin : g_mode
      assign mode_active[gm] = (mode_q == ppms_mode_t'(gm)); // RULE_18
    end
  endgenerate

  // capabilities that follow from the active mode
  assign active_mode = mode_q;
  assign port_enable = fe; // RULE_15
  assign ecp_sub_mode = ecr_q[PPMS_MODE_HI:PPMS_MODE_LO]; // RULE_08
  assign compat_refine = dyn_cfg(cfg_q) && ctrl2[PPMS_CTRL2_COMPAT_BIT]; // RULE_17
  assign ieee1284_ok = (mode_q != PPMS_EPP17); // RULE_05
  assign pd_out_only = (mode_q == PPMS_SPP_COMPAT) || (mode_q == PPMS_FIFO_PRN); // RULE_02
  assign pd_bidir = !pd_out_only; // RULE_04
  assign hw_handshake = (mode_q != PPMS_SPP_COMPAT) && (mode_q != PPMS_SPP_EXT); // RULE_03
  assign fifo_enable = (mode_q == PPMS_FIFO_PRN) || (mode_q == PPMS_ECP); // RULE_03
  assign fifo_bidir = (mode_q == PPMS_ECP); // RULE_06
  assign fifo_depth = (mode_q == PPMS_ECP) ? PPMS_ECP_FIFO_DEPTH : 5'h00; // RULE_06
  assign dma_capable = fifo_enable; // RULE_06
  assign io_data_out = dout_q;
  assign io_data_oe = oe_q;
  assign cfg_rdata = cfg_rd_q;

  // interrupt and dma routing
  ppms_route u_route (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .enable(fe),
    .irq_sel(irq_sel_q),
    .dma_sel(dma_sel_q),
    .port_irq(port_irq),
    .port_drq(port_drq && dma_capable),
    .dack_n_line(dack_n_line),
    .irq_line(irq_line),
    .drq_line(drq_line),
    .port_dack_n(port_dack_n)
  );

  // checks on the decoder and register access
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_mode_onehot: assert property ($onehot(mode_active)) // RULE_18
    else $error("active mode not one-hot");
  a_reset_ecp: assert property ($fell(sys_rst) |-> mode_q == PPMS_ECP ##1 mode_q == PPMS_ECP) // RULE_07
    else $error("port not in ecp after reset");
  a_static_epp17: assert property ((!dyn_cfg(cfg_q) && cfg_q[7:5] == PPMS_CFG_EPP17) |=> mode_q == PPMS_EPP17) // RULE_09
    else $error("static epp 1.7 not selected");
  a_static_hold: assert property ((!dyn_cfg(cfg_q) && $stable(cfg_q)) |=> $stable(mode_q)) // RULE_19
    else $error("static mode moved by run-time write");
  a_dyn_ecp: assert property ((dyn_cfg(cfg_q) && ecr_q[7:5] == PPMS_ECR_ECP) |=> mode_q == PPMS_ECP) // RULE_11
    else $error("dynamic ecp not selected");
  a_dyn_epp: assert property ((dyn_cfg(cfg_q) && ecr_q[7:5] == PPMS_ECR_EPP) |=>
      mode_q == ($past(ctrl2[PPMS_CTRL2_EPP_BIT]) ? PPMS_EPP19 : PPMS_EPP17)) // RULE_11
    else $error("dynamic epp revision wrong");
  a_disabled_quiet: assert property (!fe |=> !io_data_oe) // RULE_15
    else $error("bus driven while port disabled");
  a_index_write: assert property ((fe && wr_rise && io_addr == PPMS_OFS_DATA && idx_q == 8'h02) |=>
      ctrl2 == $past(din_q) ##1 mode_q == decode_mode($past(cfg_q), $past(ecr_q), $past(ctrl2))) // RULE_12
    else $error("indexed second_control_reg write lost");
  a_handshake_1284: assert property (mode_active[PPMS_EPP17] |-> !ieee1284_ok && hw_handshake) // RULE_05
    else $error("handshake class wrong for epp 1.7");

  // capability outputs must agree with the active mode
  a_spp_out_only: assert property (mode_active[PPMS_SPP_COMPAT] |-> pd_out_only && !hw_handshake) // RULE_02
    else $error("spp compatible not output only");

  a_ext_bidir: assert property (mode_active[PPMS_SPP_EXT] |-> pd_bidir && !fifo_enable) // RULE_04
    else $error("spp extended not bidirectional");

  a_fifo_prn: assert property (mode_active[PPMS_FIFO_PRN] |-> pd_out_only && hw_handshake && fifo_enable) // RULE_03
    else $error("fifo printer capabilities wrong");

  a_fifo_ecp: assert property (fifo_bidir |-> fifo_enable && dma_capable && fifo_depth == PPMS_ECP_FIFO_DEPTH) // RULE_06
    else $error("ecp fifo capabilities wrong");

  // a data write with the index outside the file must leave second_control_reg alone
  a_index_refused: assert property ((fe && wr_rise && io_addr == PPMS_OFS_DATA && !sec_ok) |=> $stable(ctrl2)) // RULE_12
    else $error("out-of-range index write reached second_control_reg");

  // scenarios the bench reaches, except c_spp_ext_read: every bus read runs in ecp
  c_epp19: cover property (dyn_cfg(cfg_q) ##1 mode_q == PPMS_EPP19);
  c_fifo_prn: cover property (mode_q == PPMS_FIFO_PRN);
  c_spp_ext_read: cover property (mode_q == PPMS_SPP_EXT && io_data_oe);
  c_static_epp17: cover property (!dyn_cfg(cfg_q) && mode_q == PPMS_EPP17);
  c_refine: cover property (compat_refine && mode_q == PPMS_SPP_COMPAT);

endmodule : ppms_mode_select

// File: dv/ppms_dma_peer.sv
// ppms_dma_peer: behavioural isa dma controller answering the port's dma requests
`timescale 1ns/1ns
module ppms_dma_peer #(
  parameter int LAG = 1 // cycles from request to acknowledge, 1 to 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] drq_line,
  output logic [2:0] dack_n_line
);
  logic [2:0] lag_q [4]; // acknowledge delay line, active low
  // each channel acknowledges its own request after LAG cycles and releases LAG cycles after it drops
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lag_q <= '{3'h7, 3'h7, 3'h7, 3'h7};
    end else begin
      lag_q[0] <= ~drq_line;
      lag_q[1] <= lag_q[0];
      lag_q[2] <= lag_q[1];
      lag_q[3] <= lag_q[2];
    end
  end
  assign dack_n_line = lag_q[LAG-1];
endmodule : ppms_dma_peer

// File: dv/testbench.sv
// testbench: self-checking bench for the parallel port mode selection block
`timescale 1ns/1ns
module testbench;
  import ppms_pkg::*;
  typedef struct packed {
    logic [7:0] cfg; // port configuration byte
    logic [7:0] extended_mode_control; // extended control byte
    logic [7:0] c2; // second control byte
    ppms_mode_t md; // expected mode
    logic rf; // expected compatibility refinement
  } ppms_row_t;
  logic ref_clk, sys_rst, io_rd_n, io_wr_n, io_data_oe, cfg_wr, port_enable, compat_refine;
  logic ieee1284_ok, pd_out_only, pd_bidir, hw_handshake, fifo_enable, fifo_bidir, dma_capable;
  logic port_irq, port_drq, port_dack_n;
  logic [10:0] io_addr; // bus offset from port base
  logic [7:0] io_data_in, io_data_out, cfg_index, cfg_wdata, cfg_rdata, func_enable_one;
  logic [5:0] mode_active;
  logic [2:0] ecp_sub_mode, dack_n_line, drq_line;
  logic [4:0] fifo_depth;
  logic [15:0] irq_line;
  ppms_mode_t active_mode;
  int n_fail = 0, total_checks = 0, cycles = 0;
  logic [7:0] rd_d; // read data seen
  logic rd_oe; // read was answered
  ppms_row_t rows [14] = '{
    '{8'hF0, 8'h00, 8'h00, PPMS_SPP_COMPAT, 1'b0}, '{8'hF0, 8'h20, 8'h00, PPMS_SPP_EXT, 1'b0},
    '{8'hF0, 8'h40, 8'h00, PPMS_FIFO_PRN, 1'b0}, '{8'hF0, 8'h60, 8'h00, PPMS_ECP, 1'b0},
    '{8'hF0, 8'h80, 8'h00, PPMS_EPP17, 1'b0}, '{8'hF0, 8'h80, 8'h10, PPMS_EPP19, 1'b0},
    '{8'hF0, 8'h00, 8'h80, PPMS_SPP_COMPAT, 1'b1}, '{8'hD0, 8'h20, 8'h00, PPMS_SPP_EXT, 1'b0},
    '{8'h00, 8'h60, 8'h80, PPMS_SPP_COMPAT, 1'b0}, '{8'h20, 8'h00, 8'h00, PPMS_SPP_EXT, 1'b0},
    '{8'h40, 8'h00, 8'h10, PPMS_EPP17, 1'b0}, '{8'h60, 8'h00, 8'h00, PPMS_EPP19, 1'b0},
    '{8'h80, 8'h00, 8'h00, PPMS_ECP, 1'b0}, '{8'hE0, 8'h00, 8'h00, PPMS_ECP, 1'b0}
  };
  ppms_mode_select u_ppms_mode_select (.ref_clk(ref_clk), .sys_rst(sys_rst), .io_addr(io_addr),
    .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_data_in(io_data_in), .io_data_out(io_data_out),
    .io_data_oe(io_data_oe), .cfg_wr(cfg_wr), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .func_enable_one(func_enable_one), .port_enable(port_enable),
    .active_mode(active_mode), .mode_active(mode_active), .ecp_sub_mode(ecp_sub_mode),
    .compat_refine(compat_refine), .ieee1284_ok(ieee1284_ok), .pd_out_only(pd_out_only),
    .pd_bidir(pd_bidir), .hw_handshake(hw_handshake), .fifo_enable(fifo_enable), .fifo_bidir(fifo_bidir),
    .fifo_depth(fifo_depth), .dma_capable(dma_capable), .port_irq(port_irq), .port_drq(port_drq),
    .dack_n_line(dack_n_line), .irq_line(irq_line), .drq_line(drq_line), .port_dack_n(port_dack_n));
  ppms_dma_peer #(.LAG(2)) u_ppms_dma_peer (.ref_clk(ref_clk), .sys_rst(sys_rst), .drq_line(drq_line),
    .dack_n_line(dack_n_line));
  // clock generation
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // write strobe held low 6 cycles, then idle long enough for the commit to land
  task automatic bus_wr(input logic [10:0] a, input logic [7:0] d);
    io_addr = a;
    io_data_in = d;
    io_wr_n = 1'b0;
    cyc(6);
    io_wr_n = 1'b1;
    cyc(10);
  endtask : bus_wr
  // read strobe held until the block drives the bus or the wait runs out
  task automatic bus_rd(input logic [10:0] a, output logic [7:0] d, output logic oe);
    int k;
    io_addr = a;
    io_rd_n = 1'b0;
    oe = 1'b0;
    d = 8'h00;
    for (k = 0; k < 10 && !oe; k++) begin
      cyc(1);
      if (io_data_oe === 1'b1) begin
        oe = 1'b1;
        d = io_data_out;
      end
    end
    io_rd_n = 1'b1;
    cyc(8);
  endtask : bus_rd
  task automatic cfg_write(input logic [7:0] i, input logic [7:0] d);
    cfg_index = i;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(3);
  endtask : cfg_write
  // every mode-derived output but compat_refine is worked out from the expected mode alone
  task automatic chk_mode(input ppms_mode_t m, input logic rf);
    chk("active_mode", 16'(m), 16'(active_mode));
    chk("mode_active", 16'(6'h01 << m), 16'(mode_active));
    chk("ieee1284_ok", 16'(m != PPMS_EPP17), 16'(ieee1284_ok));
    chk("pd_out_only", 16'(m == PPMS_SPP_COMPAT || m == PPMS_FIFO_PRN), 16'(pd_out_only));
    chk("pd_bidir", 16'(!(m == PPMS_SPP_COMPAT || m == PPMS_FIFO_PRN)), 16'(pd_bidir));
    chk("fifo_enable", 16'(m == PPMS_FIFO_PRN || m == PPMS_ECP), 16'(fifo_enable));
    chk("fifo_bidir", 16'(m == PPMS_ECP), 16'(fifo_bidir));
    chk("dma_capable", 16'(m == PPMS_FIFO_PRN || m == PPMS_ECP), 16'(dma_capable));
    chk("hw_handshake", 16'(m != PPMS_SPP_COMPAT && m != PPMS_SPP_EXT), 16'(hw_handshake));
    chk("fifo_depth", (m == PPMS_ECP) ? 16'h0010 : 16'h0000, 16'(fifo_depth));
    chk("compat_refine", 16'(rf), 16'(compat_refine));
  endtask : chk_mode
  task automatic reset_dut();
    sys_rst = 1'b1;
    cyc(3);
    sys_rst = 1'b0;
    cyc(1);
    chk_mode(PPMS_ECP, 1'b0);
    chk("ecp_sub_mode", 16'h0003, 16'(ecp_sub_mode));
    chk("drq_line", 16'h0000, 16'(drq_line));
  endtask : reset_dut
  initial begin
    sys_rst = 1'b1;
    io_addr = 11'h000;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    io_data_in = 8'h00;
    cfg_wr = 1'b0;
    cfg_index = 8'h00;
    cfg_wdata = 8'h00;
    func_enable_one = 8'h10;
    port_irq = 1'b0;
    port_drq = 1'b0;
    reset_dut();
    foreach (rows[i]) begin
      cfg_write(PPMS_CFG_IDX_PP, rows[i].cfg);
      bus_wr(PPMS_OFS_ECR, rows[i].extended_mode_control);
      bus_wr(PPMS_OFS_IDX, 8'h02);
      bus_wr(PPMS_OFS_DATA, rows[i].c2);
      chk_mode(rows[i].md, rows[i].rf);
      chk("ecp_sub_mode", 16'(rows[i].extended_mode_control[7:5]), 16'(ecp_sub_mode));
      cyc(1);
      chk("cfg_rdata", 16'(rows[i].cfg), 16'(cfg_rdata));
    end
    // indirect registers: readback, out-of-range index, unmapped offset, stability
    bus_rd(PPMS_OFS_ECR, rd_d, rd_oe);
    chk("ecr_read", 16'h0100, {7'h00, rd_oe, rd_d});
    bus_rd(PPMS_OFS_DATA, rd_d, rd_oe);
    chk("ctrl2_read", 16'h0100, {7'h00, rd_oe, rd_d});
    bus_wr(PPMS_OFS_IDX, 8'h09);
    bus_wr(PPMS_OFS_DATA, 8'h55);
    bus_rd(PPMS_OFS_DATA, rd_d, rd_oe);
    chk("idx9_read", 16'h0100, {7'h00, rd_oe, rd_d});
    bus_rd(PPMS_OFS_IDX, rd_d, rd_oe);
    chk("idx_read", 16'h0109, {7'h00, rd_oe, rd_d});
    bus_rd(11'h405, rd_d, rd_oe);
    chk("unmapped_oe", 16'h0000, 16'(rd_oe));
    chk("active_mode", 16'(PPMS_ECP), 16'(active_mode));
    // disabled port refuses writes and reads
    func_enable_one = 8'hEF;
    cyc(1);
    chk("port_enable", 16'h0000, 16'(port_enable));
    bus_wr(PPMS_OFS_ECR, 8'hA0);
    bus_rd(PPMS_OFS_ECR, rd_d, rd_oe);
    chk("disabled_oe", 16'h0000, 16'(rd_oe));
    func_enable_one = 8'h10;
    cyc(1);
    bus_rd(PPMS_OFS_ECR, rd_d, rd_oe);
    chk("ecr_kept", 16'h0100, {7'h00, rd_oe, rd_d});
    // interrupt routing over every selector value
    port_irq = 1'b1;
    for (int s = 0; s < 16; s++) begin
      cfg_write(PPMS_CFG_IDX_IRQ, 8'(s));
      chk("irq_line", (s == 0 || s == 2 || s == 13) ? 16'h0000 : 16'h0001 << s, irq_line);
    end
    port_irq = 1'b0;
    cyc(2);
    chk("irq_idle", 16'h0000, irq_line);
    chk("irq_rdata", 16'h000F, 16'(cfg_rdata));
    // dma routing with the peer acknowledging, ecp mode is dma capable
    port_drq = 1'b1;
    for (int c = 0; c < 4; c++) begin
      cfg_write(PPMS_CFG_IDX_DMA, 8'(c));
      cyc(4);
      chk("drq_line", (c < 3) ? 16'h0001 << c : 16'h0000, 16'(drq_line));
      chk("port_dack_n", (c < 3) ? 16'h0000 : 16'h0001, 16'(port_dack_n));
    end
    cfg_write(PPMS_CFG_IDX_DMA, 8'h01);
    cfg_write(PPMS_CFG_IDX_PP, 8'h00);
    cyc(2);
    chk("drq_gated", 16'h0000, 16'(drq_line));
    port_drq = 1'b0;
    // second reset mid-run returns to the defaults
    reset_dut();
    cyc(1);
    chk("cfg_rst", 16'(PPMS_CFG_RST), 16'(cfg_rdata));
    end_sim();
  end
endmodule : testbench
